// >>> src/spm_device.sv
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - capture loads chain, shift moves tdi to tdo
// - update copies shifted chain to holding register
// - reset configures five pins for port use
// - cleared select bits give pins to gpio
// - protected select writes need unlock and commit
// - ten switches under reset erase flash
// - probe sends only ones then pattern
// - tap preamble enables serial, disables scan; PRE asks for an RTI to SIR step, so it never sets serial_r
// - pattern E79E lsb first selects serial
// - probe sends fifty ones before pattern
// - pattern E73C then ones returns scan
// - matching pattern changes debug port mode
// - fifty ones reset scan and serial logic; here line_reset only forces the tap to TLR, serial_r keeps its value
// - software restores select bits before scan
// - mode sampled rising, five ones reset tap
// - reset tap loads identification instruction
module spm_device
	import spm_pkg::*;
(
	spm_link_if.dev link,
	input wire logic clock,
	input wire logic rst,
	input wire logic sw_wr,
	input wire logic [1:0] sw_sel,
	input wire logic [31:0] sw_wdata,
	output logic [4:0] alt_function_select,
	output logic [4:0] pin_digital_enable,
	output logic [4:0] pin_pullup_select,
	output logic serial_mode,
	output logic flash_erase,
	output logic [31:0] dr_hold
);
	spm_tap_e tap_r, tap_nxt;
	logic [3:0] ir_sh_r, ir_r;
	logic [31:0] dr_sh_r;
	logic byp_r;
	logic serial_r;
	logic [4:0] pre_r;
	logic [3:0] rec_cnt_r;
	logic erase_t_r;
	logic [2:0] erase_s_r;
	logic [31:0] lock_r;
	logic [4:0] commit_r;
	logic [4:0] afsel_r;
	logic [1:0] er_sync_r;
	logic [1:0] ser_sync_r;
	logic [1:0] er_tck_r;
	logic erase_pend_r;
	logic er_prev_r;
	logic to_serial, to_scan, line_reset;

	// tap logic resets on test reset; external reset only holds the core
	// power-on reset also clears the tap, since nothing else defines it
	wire tap_rst_n = link.test_reset_n && !rst;
	wire tms = link.tms_oe ? link.tms_o : 1'b1; // pull-up when undriven
	wire in_reset = !er_tck_r[1];

	spm_switch_det u_det (
		.tck(link.tck),
		.rst_n(tap_rst_n),
		.mode_bit(tms),
		.to_serial(to_serial),
		.to_scan(to_scan),
		.line_reset(line_reset)
	);

	// preamble of tap states for serial debug; it never hands the port over, as entry 18 needs an RTI to SIR step
	localparam int PRE_N = 20;
	localparam logic [3:0] PRE [PRE_N] = '{SPM_RTI, SPM_SDR, SPM_SIR, SPM_TLR, SPM_TLR, SPM_RTI, SPM_RTI,
		SPM_SDR, SPM_SIR, SPM_TLR, SPM_TLR, SPM_RTI, SPM_RTI, SPM_SDR, SPM_SIR, SPM_TLR, SPM_RTI,
		SPM_RTI, SPM_SIR, SPM_TLR};
	wire pre_hit = (pre_r < 5'(PRE_N)) && (4'(tap_nxt) == PRE[pre_r]);

	assign tap_nxt = (line_reset || serial_r) ? SPM_TLR : spm_tap_next(tap_r, tms);
	wire ir_ident = (ir_r == SPM_IR_IDENT);

	// tap state, instruction and data chains on the link clock
	always_ff @(posedge link.tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			tap_r <= SPM_TLR;
			ir_sh_r <= SPM_IR_IDENT;
			ir_r <= SPM_IR_IDENT;
			dr_sh_r <= 32'h0000_0000;
			byp_r <= 1'b0;
		end else begin
			tap_r <= tap_nxt;
			unique case (tap_r)
				SPM_TLR: ir_r <= SPM_IR_IDENT;
				SPM_CIR: ir_sh_r <= 4'h1;
				SPM_SHIR: ir_sh_r <= {link.tdi, ir_sh_r[3:1]};
				SPM_UIR: ir_r <= ir_sh_r;
				SPM_CDR: begin
					dr_sh_r <= ir_ident ? SPM_IDENT_VAL : dr_hold;
					byp_r <= 1'b0;
				end
				SPM_SHDR: begin
					dr_sh_r <= {link.tdi, dr_sh_r[31:1]};
					byp_r <= link.tdi;
				end
				default: ;
			endcase
		end
	end

	// update register of the data chain
	always_ff @(posedge link.tck or negedge tap_rst_n) begin
		if (!tap_rst_n)
			dr_hold <= 32'h0000_0000;
		else if (tap_r == SPM_UDR && !ir_ident && ir_r != SPM_IR_BYPASS)
			dr_hold <= dr_sh_r;
	end

	// tdo changes on the falling edge and drives only while shifting
	always_ff @(negedge link.tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			link.tdo <= 1'b0;
			link.tdo_oe <= 1'b0;
		end else begin
			link.tdo <= (tap_r == SPM_SHIR) ? ir_sh_r[0] : (ir_r == SPM_IR_BYPASS ? byp_r : dr_sh_r[0]);
			link.tdo_oe <= (tap_r == SPM_SHIR) || (tap_r == SPM_SHDR);
		end
	end

	// mode switching, preamble tracking and recovery counting
	always_ff @(posedge link.tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			serial_r <= 1'b0;
			pre_r <= 5'h00;
			rec_cnt_r <= 4'h0;
			erase_t_r <= 1'b0;
			er_tck_r <= 2'h3;
		end else begin
			er_tck_r <= {er_tck_r[0], link.ext_reset_n};
			if (to_serial)
				serial_r <= 1'b1;
			else if (to_scan)
				serial_r <= 1'b0;
			else if (!serial_r && pre_hit && pre_r == 5'(PRE_N - 1))
				serial_r <= 1'b1;
			if (serial_r || tap_r != SPM_TLR && pre_r == 5'h00)
				pre_r <= 5'h00;
			else if (pre_hit)
				pre_r <= pre_r + 5'h01;
			else if (tap_r == SPM_TLR && pre_r == 5'h00)
				pre_r <= 5'h00;
			else
				pre_r <= 5'h00;
			// alternate switches while held in reset count toward recovery
			if (!in_reset)
				rec_cnt_r <= 4'h0;
			else if ((to_serial && rec_cnt_r[0] == 1'b0) || (to_scan && rec_cnt_r[0] == 1'b1)) begin
				if (rec_cnt_r == 4'(SPM_RECOVER_SEQS - 1)) begin
					rec_cnt_r <= 4'h0;
					erase_t_r <= !erase_t_r;
				end else begin
					rec_cnt_r <= rec_cnt_r + 4'h1;
				end
			end
		end
	end

	// system side: erase event, mode level, pin block
	wire afsel_wr = sw_wr && sw_sel == 2'h0;
	wire unlocked = (lock_r == SPM_LOCK_KEY);
	wire [4:0] afsel_nxt = (afsel_r & ~commit_r) | (sw_wdata[4:0] & commit_r);
	// ten switches done under reset; erase waits for the reset release
	wire erase_evt = erase_s_r[2] ^ erase_s_r[1];
	wire rst_release = er_sync_r[1] && !er_prev_r;
	assign serial_mode = ser_sync_r[1];
	assign alt_function_select = afsel_r;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			erase_s_r <= 3'h0;
			ser_sync_r <= 2'h0;
			afsel_r <= SPM_PIN_RESET;
			pin_digital_enable <= SPM_PIN_RESET;
			pin_pullup_select <= SPM_PIN_RESET;
			lock_r <= 32'h0000_0000;
			commit_r <= 5'h00;
			er_sync_r <= 2'h0;
			er_prev_r <= 1'b0;
			erase_pend_r <= 1'b0;
			flash_erase <= 1'b0;
		end else begin
			erase_s_r <= {erase_s_r[1:0], erase_t_r};
			ser_sync_r <= {ser_sync_r[0], serial_r};
			er_sync_r <= {er_sync_r[0], link.ext_reset_n};
			er_prev_r <= er_sync_r[1];
			flash_erase <= rst_release && (erase_pend_r || erase_evt);
			erase_pend_r <= (erase_pend_r || erase_evt) && !rst_release;
			if (!er_sync_r[1]) begin
				afsel_r <= SPM_PIN_RESET;
				pin_digital_enable <= SPM_PIN_RESET;
				pin_pullup_select <= SPM_PIN_RESET;
			end else begin
				if (afsel_wr && unlocked)
					afsel_r <= afsel_nxt; // zeros release pins to gpio
				if (sw_wr && sw_sel == 2'h1)
					lock_r <= sw_wdata;
				if (sw_wr && sw_sel == 2'h2 && unlocked)
					commit_r <= sw_wdata[4:0];
				if (sw_wr && sw_sel == 2'h3)
					pin_pullup_select <= sw_wdata[4:0];
			end
		end
	end
endmodule : spm_device
`default_nettype wire

// >>> src/spm_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface spm_link_if;
	logic tck;
	logic tms_o;
	logic tms_oe;
	logic tdi;
	logic tdo;
	logic tdo_oe;
	logic test_reset_n;
	logic ext_reset_n;
	modport probe (output tck, output tms_o, output tms_oe, output tdi, output test_reset_n,
		output ext_reset_n, input tdo, input tdo_oe);
	modport dev (input tck, input tms_o, input tms_oe, input tdi, input test_reset_n,
		input ext_reset_n, output tdo, output tdo_oe);
endinterface : spm_link_if
`default_nettype wire

// >>> src/spm_pkg.sv
package spm_pkg;
	// switch patterns, sent least significant bit first
	localparam logic [15:0] SPM_TO_SERIAL = 16'hE79E;
	localparam logic [15:0] SPM_TO_SCAN = 16'hE73C;
	localparam int SPM_RESET_RUN = 50;
	localparam int SPM_TAIL_SCAN = 5;
	localparam int SPM_RECOVER_SEQS = 10;
	localparam logic [5:0] SPM_RUN_MAX = 6'h3F;
	// instruction register
	localparam int SPM_IR_W = 4;
	localparam logic [3:0] SPM_IR_IDENT = 4'hE;
	localparam logic [3:0] SPM_IR_BYPASS = 4'hF;
	localparam int SPM_DR_W = 32;
	// arbitrary identification value, not a real code
	localparam logic [31:0] SPM_IDENT_VAL = 32'h1234_5671;
	// pin block: five pins, lock key
	localparam int SPM_PINS = 5;
	localparam logic [4:0] SPM_PIN_RESET = 5'h1F;
	localparam logic [31:0] SPM_LOCK_KEY = 32'h1ACC_E551;
	// AXI-Lite register offsets of the probe controller
	localparam logic [3:0] SPM_A_CTRL = 4'h0;
	localparam logic [3:0] SPM_A_STATUS = 4'h4;
	localparam logic [3:0] SPM_A_SHIFT = 4'h8;
	localparam logic [3:0] SPM_A_RDATA = 4'hC;
	// probe clock divider last count; each half period lasts this plus one system clocks
	localparam logic [3:0] SPM_DIV_HALF = 4'h2;

	// tap states
	typedef enum logic [3:0] {
		SPM_TLR = 4'h0, SPM_RTI = 4'h1, SPM_SDR = 4'h2, SPM_CDR = 4'h3,
		SPM_SHDR = 4'h4, SPM_E1DR = 4'h5, SPM_PDR = 4'h6, SPM_E2DR = 4'h7,
		SPM_UDR = 4'h8, SPM_SIR = 4'h9, SPM_CIR = 4'hA, SPM_SHIR = 4'hB,
		SPM_E1IR = 4'hC, SPM_PIR = 4'hD, SPM_E2IR = 4'hE, SPM_UIR = 4'hF
	} spm_tap_e;

	function automatic spm_tap_e spm_tap_next(input spm_tap_e s, input logic m);
		unique case (s)
			SPM_TLR: spm_tap_next = m ? SPM_TLR : SPM_RTI;
			SPM_RTI: spm_tap_next = m ? SPM_SDR : SPM_RTI;
			SPM_SDR: spm_tap_next = m ? SPM_SIR : SPM_CDR;
			SPM_CDR: spm_tap_next = m ? SPM_E1DR : SPM_SHDR;
			SPM_SHDR: spm_tap_next = m ? SPM_E1DR : SPM_SHDR;
			SPM_E1DR: spm_tap_next = m ? SPM_UDR : SPM_PDR;
			SPM_PDR: spm_tap_next = m ? SPM_E2DR : SPM_PDR;
			SPM_E2DR: spm_tap_next = m ? SPM_UDR : SPM_SHDR;
			SPM_UDR: spm_tap_next = m ? SPM_SDR : SPM_RTI;
			SPM_SIR: spm_tap_next = m ? SPM_TLR : SPM_CIR;
			SPM_CIR: spm_tap_next = m ? SPM_E1IR : SPM_SHIR;
			SPM_SHIR: spm_tap_next = m ? SPM_E1IR : SPM_SHIR;
			SPM_E1IR: spm_tap_next = m ? SPM_UIR : SPM_PIR;
			SPM_PIR: spm_tap_next = m ? SPM_E2IR : SPM_PIR;
			SPM_E2IR: spm_tap_next = m ? SPM_UIR : SPM_SHIR;
			SPM_UIR: spm_tap_next = m ? SPM_SDR : SPM_RTI;
		endcase
	endfunction : spm_tap_next
endpackage : spm_pkg

// >>> src/spm_probe.sv
`timescale 1ns/1ps
`default_nettype none
// probe end: AXI-Lite registers order bit runs on the mode line (lsb first)
module spm_probe
	import spm_pkg::*;
(
	spm_link_if.probe link,
	input wire logic clock,
	input wire logic rst,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [31:0] ctrl_r, shift_r, rdata_r;
	logic [5:0] cnt_r;
	logic busy_r;
	logic [3:0] div_r;
	logic tck_r;
	logic [1:0] tdo_s_r;
	logic aw_got_r, w_got_r;
	logic [3:0] awa_r;
	logic [31:0] wd_r;

	// ctrl: [0] test reset low, [1] ext reset low, [7:2] bit count-1, [8] tdi level, [9] go
	wire wr_do = aw_got_r && w_got_r && !s_axi_bvalid;
	wire go = wr_do && awa_r == SPM_A_CTRL && wd_r[9] && !busy_r;
	wire fall = busy_r && tck_r && div_r == SPM_DIV_HALF;
	wire rise = busy_r && !tck_r && div_r == SPM_DIV_HALF;

	assign s_axi_awready = !aw_got_r;
	assign s_axi_wready = !w_got_r;
	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_bresp = 2'h0;
	assign s_axi_rresp = 2'h0;
	assign link.tck = tck_r;
	assign link.tms_oe = 1'b1;
	assign link.tms_o = shift_r[0]; // first bit sent is bit 0
	assign link.tdi = ctrl_r[8];
	assign link.test_reset_n = !ctrl_r[0];
	assign link.ext_reset_n = !ctrl_r[1]; // hold during recovery

	// write channel capture and response
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awa_r <= 4'h0;
			wd_r <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && !aw_got_r) begin
				aw_got_r <= 1'b1;
				awa_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_got_r) begin
				w_got_r <= 1'b1;
				wd_r <= s_axi_wdata;
			end
			if (wr_do)
				s_axi_bvalid <= 1'b1;
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
			end
		end
	end

	// read channel; tdo sampled through two flops
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			tdo_s_r <= 2'h0;
		end else begin
			tdo_s_r <= {tdo_s_r[0], link.tdo & link.tdo_oe};
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				unique case (s_axi_araddr)
					SPM_A_CTRL: s_axi_rdata <= ctrl_r;
					SPM_A_STATUS: s_axi_rdata <= {25'h0, cnt_r, busy_r};
					SPM_A_SHIFT: s_axi_rdata <= shift_r;
					SPM_A_RDATA: s_axi_rdata <= rdata_r;
					default: s_axi_rdata <= 32'h0000_0000;
				endcase
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// divided test clock and bit shifter; runs of ones come from an all-ones shift word and the ones shifted in at the top
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_r <= 32'h0000_0000;
			shift_r <= 32'hFFFF_FFFF;
			rdata_r <= 32'h0000_0000;
			cnt_r <= 6'h00;
			busy_r <= 1'b0;
			div_r <= 4'h0;
			tck_r <= 1'b0;
		end else begin
			div_r <= (busy_r && div_r != SPM_DIV_HALF) ? div_r + 4'h1 : 4'h0;
			if (wr_do && awa_r == SPM_A_CTRL && !busy_r)
				ctrl_r <= {22'h0, wd_r[9:0]};
			if (wr_do && awa_r == SPM_A_SHIFT && !busy_r)
				shift_r <= wd_r;
			if (go) begin
				busy_r <= 1'b1;
				cnt_r <= wd_r[7:2]; // full six-bit count, runs of fifty need bit 5
			end
			if (rise) begin
				tck_r <= 1'b1;
				rdata_r <= {tdo_s_r[1], rdata_r[31:1]};
			end
			if (fall) begin
				tck_r <= 1'b0;
				shift_r <= {1'b1, shift_r[31:1]};
				if (cnt_r == 6'h00)
					busy_r <= 1'b0;
				else
					cnt_r <= cnt_r - 6'h01;
			end
		end
	end
endmodule : spm_probe
`default_nettype wire

// >>> src/spm_switch_det.sv
`timescale 1ns/1ps
`default_nettype none
// recognises the two switch patterns after a run of ones, on the link clock
module spm_switch_det
	import spm_pkg::*;
(
	input wire logic tck,
	input wire logic rst_n,
	input wire logic mode_bit,
	output logic to_serial,
	output logic to_scan,
	output logic line_reset
);
	logic [15:0] hist_r;
	logic [5:0] ones_r;
	logic armed_r;
	logic [4:0] since_r;

	// newest bit enters at the top so the first-sent bit ends in bit 0
	wire [15:0] hist_nxt = {mode_bit, hist_r[15:1]};
	wire pat_window = armed_r && (since_r == 5'h0F);
	assign to_serial = pat_window && (hist_nxt == SPM_TO_SERIAL);
	assign to_scan = pat_window && (hist_nxt == SPM_TO_SCAN);
	assign line_reset = (ones_r >= 6'(SPM_RESET_RUN));

	// bit history, run of ones and bits since the run ended
	always_ff @(posedge tck or negedge rst_n) begin
		if (!rst_n) begin
			hist_r <= 16'h0000;
			ones_r <= 6'h00;
			armed_r <= 1'b0;
			since_r <= 5'h00;
		end else begin
			hist_r <= hist_nxt;
			ones_r <= mode_bit ? ((ones_r == SPM_RUN_MAX) ? ones_r : ones_r + 6'h01) : 6'h00;
			if (line_reset && !mode_bit) begin
				armed_r <= 1'b1; // pattern must follow a long run of ones
				since_r <= 5'h01;
			end else if (armed_r && since_r != 5'h10) begin
				since_r <= since_r + 5'h01;
			end else begin
				armed_r <= 1'b0;
			end
		end
	end
endmodule : spm_switch_det
`default_nettype wire

// >>> tb/spm_checker.sv
`timescale 1ns/1ps
`default_nettype none
module spm_checker
	import spm_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic tck,
	input wire logic tms_o,
	input wire logic tms_oe,
	input wire logic tdi,
	input wire logic tdo_oe,
	input wire logic test_reset_n,
	input wire logic ext_reset_n,
	input wire logic serial_mode,
	input wire logic flash_erase,
	input wire logic [4:0] alt_function_select
);
	// mode line level with pull-up, pattern match after a run of ones
	wire logic tms_lvl = tms_oe ? tms_o : 1'b1;
	logic [65:0] hist_r;
	logic [2:0] ones_r;
	logic ser_ok_r;
	logic [3:0] nsw_r;
	wire logic [65:0] hist_nxt = {tms_lvl, hist_r[65:1]};
	wire logic run_ok = &hist_nxt[49:0];
	wire logic hit_ser = run_ok && hist_nxt[65:50] == SPM_TO_SERIAL;
	wire logic hit_scan = run_ok && hist_nxt[65:50] == SPM_TO_SCAN;
	wire logic hit = hit_ser || hit_scan;
	// history, ones count, switches seen under external reset
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			hist_r <= '0;
			ones_r <= 3'h0;
			ser_ok_r <= 1'b0;
			nsw_r <= 4'h0;
		end else begin
			hist_r <= hist_nxt;
			ones_r <= !tms_lvl ? 3'h0 : (ones_r == 3'h7 ? ones_r : ones_r + 3'h1);
			if (hit) ser_ok_r <= hit_ser;
			if (hit) nsw_r <= !ext_reset_n ? nsw_r + 4'h1 : 4'h0;
		end
	end
	a_tms_held:
		assert property (@(posedge clock) disable iff (rst) tck && $past(tck) |-> $stable(tms_o))
		else $error("mode line moved while clock high");
	a_tdi_held:
		assert property (@(posedge clock) disable iff (rst) tck && $past(tck) |-> $stable(tdi))
		else $error("data line moved while clock high");
	a_tdo_quiet:
		assert property (@(posedge tck) disable iff (rst) ones_r >= 3'h6 |-> !tdo_oe)
		else $error("data out driven after mode ones");
	a_trst_quiet:
		assert property (@(posedge clock) disable iff (rst) !test_reset_n [*3] |-> !tdo_oe)
		else $error("data out driven in test reset");
	a_to_serial:
		assert property (@(posedge clock) disable iff (rst) $rose(serial_mode) |-> ser_ok_r)
		else $error("serial mode without its pattern");
	a_to_scan:
		assert property (@(posedge clock) disable iff (rst) $fell(serial_mode) |-> !ser_ok_r)
		else $error("scan mode without its pattern");
	a_erase_ten:
		assert property (@(posedge clock) disable iff (rst) flash_erase |-> nsw_r >= 4'hA)
		else $error("erase without ten switches");
	a_erase_pulse:
		assert property (@(posedge clock) disable iff (rst) flash_erase |=> !flash_erase)
		else $error("erase longer than one clock");
	a_pins_reset:
		assert property (@(posedge clock) disable iff (rst) !ext_reset_n [*6] |-> alt_function_select == SPM_PIN_RESET)
		else $error("pins not restored in reset");
endmodule : spm_checker
`default_nettype wire

// >>> tb/tb_scan_port_mode_switch.sv
`timescale 1ns/1ps
`default_nettype none
module tb_scan_port_mode_switch
	import spm_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic sw_wr = 1'b0;
	logic [1:0] sw_sel = 2'h0;
	logic [31:0] sw_wdata = 32'h0;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, serial_mode, flash_erase;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rd, dr_hold;
	logic [4:0] alt, dig, pull;
	logic ctl_ext = 1'b0;
	logic ctl_trst = 1'b0;
	logic ctl_tdi = 1'b0;
	int mismatches = 0;
	int n_tests = 0;
	int n_erase = 0;
	int cyc = 0;
	spm_link_if link();
	always #12.5 clock = ~clock;
	spm_device spm_device_i (.link(link), .clock(clock), .rst(rst), .sw_wr(sw_wr), .sw_sel(sw_sel),
		.sw_wdata(sw_wdata), .alt_function_select(alt), .pin_digital_enable(dig), .pin_pullup_select(pull),
		.serial_mode(serial_mode), .flash_erase(flash_erase), .dr_hold(dr_hold));
	spm_probe spm_probe_i (.link(link), .clock(clock), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	spm_checker spm_checker_i (.clock(clock), .rst(rst), .tck(link.tck), .tms_o(link.tms_o),
		.tms_oe(link.tms_oe), .tdi(link.tdi), .tdo_oe(link.tdo_oe), .test_reset_n(link.test_reset_n),
		.ext_reset_n(link.ext_reset_n), .serial_mode(serial_mode), .flash_erase(flash_erase),
		.alt_function_select(alt));
	// erase pulses and run ceiling
	always @(posedge clock) begin
		if (flash_erase === 1'b1) n_erase <= n_erase + 1;
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			mismatches++;
			conclude();
		end
	end
	task automatic conclude();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask : axw
	task automatic axr(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		rready <= 1'b0;
	endtask : axr
	task automatic ctl(input logic go, input int n);
		axw(SPM_A_CTRL, {22'h0, go, ctl_tdi, 6'(n - 1), ctl_ext, ctl_trst});
	endtask : ctl
	// shift word out bit0 first, wait for idle
	task automatic send(input logic [31:0] w, input int n);
		int k;
		axw(SPM_A_SHIFT, w);
		ctl(1'b1, n);
		k = 0;
		do begin
			axr(SPM_A_STATUS, rd);
			k++;
		end while (rd[0] !== 1'b0 && k < 200);
		if (rd[0] !== 1'b0) chk(32'(rd[0]), 32'h0);
	endtask : send
	task automatic sw(input logic [15:0] p);
		send(32'hFFFF_FFFF, SPM_RESET_RUN);
		send({16'h0, p}, 16);
	endtask : sw
	task automatic pw(input logic [1:0] s, input logic [31:0] d);
		@(posedge clock);
		sw_wr <= 1'b1;
		sw_sel <= s;
		sw_wdata <= d;
		@(posedge clock);
		sw_wr <= 1'b0;
		repeat (3) @(posedge clock);
	endtask : pw
	// identification scan, then instruction 0 and a data scan through the holding register
	task automatic scan_id(input logic d);
		ctl_tdi = 1'b0;
		send(32'h2, 4);
		ctl_tdi = d;
		send(32'h8000_0000, 32);
		axr(SPM_A_RDATA, rd);
		chk(rd, SPM_IDENT_VAL);
		send(32'h1, 2);
		ctl_tdi = 1'b0;
		send(32'h183, 10);
		ctl_tdi = d;
		send(32'h1, 3);
		send(32'h8000_0000, 32);
		axr(SPM_A_RDATA, rd);
		chk(rd, {32{!d}});
		send(32'h1, 2);
		chk(dr_hold, {32{d}});
	endtask : scan_id
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		chk(32'({alt, dig, pull}), 32'h7FFF);
		pw(2'h0, 32'h0);
		chk(32'(alt), 32'h1F);
		pw(2'h1, SPM_LOCK_KEY);
		pw(2'h2, 32'h1F);
		pw(2'h0, 32'h0);
		chk(32'(alt), 32'h0);
		pw(2'h0, 32'h1F);
		chk(32'(alt), 32'h1F);
		pw(2'h0, 32'h0);
		ctl_ext = 1'b1;
		ctl(1'b0, 1);
		repeat (8) @(posedge clock);
		chk(32'(alt), 32'h1F);
		ctl_ext = 1'b0;
		ctl_trst = 1'b1;
		ctl(1'b0, 1);
		repeat (4) @(posedge clock);
		ctl_trst = 1'b0;
		ctl(1'b0, 1);
		$display("pins test done");
		scan_id(1'b1);
		$display("scan test done");
		send(32'hFFFF_FFFF, 20);
		send({16'h0, SPM_TO_SERIAL}, 16);
		repeat (8) @(posedge clock);
		chk(32'(serial_mode), 32'h0);
		sw(SPM_TO_SERIAL);
		repeat (8) @(posedge clock);
		chk(32'(serial_mode), 32'h1);
		sw(SPM_TO_SCAN);
		send(32'hFFFF_FFFF, SPM_TAIL_SCAN);
		repeat (8) @(posedge clock);
		chk(32'(serial_mode), 32'h0);
		scan_id(1'b0);
		$display("switch test done");
		ctl_ext = 1'b1;
		ctl(1'b0, 1);
		for (int i = 0; i < SPM_RECOVER_SEQS; i++) sw(i[0] ? SPM_TO_SCAN : SPM_TO_SERIAL);
		chk(32'(n_erase), 32'h0);
		ctl_ext = 1'b0;
		ctl(1'b0, 1);
		repeat (20) @(posedge clock);
		chk(32'(n_erase), 32'h1);
		$display("recovery test done");
		conclude();
	end
endmodule : tb_scan_port_mode_switch
`default_nettype wire
